// ==== pkg/pmaab_pkg.sv ====
// Package: register map, field layout and reset values of the ability bank
//
// Overview of operation
// R01: Extended ability one reads bit 11 as 1, fixed, announcing the abilities at offset 0x12.
// R02: Extended ability two reads bit 0 as 1 for 100BASE-T1 support, with bits 15:1 zero.
// R03: Role bit 14 is writable, 1 master and 0 slave, and its reset value comes from a strap.
// R04: Test field 15:12 is writable (0000 normal, 0010/0100/1000/1010 modes 1/2/4/5), reset from strap.
// R05: The host reaches this bank with the device space selector set to 1.
// R06: Writes to read-only or reserved bits are ignored and those bits keep their fixed values.
package pmaab_pkg;

    // ------------------------------------------------------------------
    // Register offsets (register index; byte address is four times it)
    // ------------------------------------------------------------------
    localparam logic [11:0] PMAAB_IDX_EXT_ONE  = 12'h00B;
    localparam logic [11:0] PMAAB_IDX_EXT_TWO  = 12'h012;
    localparam logic [11:0] PMAAB_IDX_ROLE     = 12'h834;
    localparam logic [11:0] PMAAB_IDX_TEST     = 12'h836;
    localparam logic [3:0]  PMAAB_SPACE_PMA    = 4'h1;

    // ------------------------------------------------------------------
    // Field positions and fixed values
    // ------------------------------------------------------------------
    localparam int          PMAAB_ROLE_BIT     = 14;
    localparam int          PMAAB_TEST_LSB     = 12;
    localparam logic [15:0] PMAAB_EXT_ONE_VAL  = 16'h0800;
    localparam logic [15:0] PMAAB_EXT_TWO_VAL  = 16'h0001;
    localparam logic [15:0] PMAAB_ROLE_FIXED   = 16'h8000;
    localparam logic [15:0] PMAAB_TEST_FIXED   = 16'h0001;

    // ------------------------------------------------------------------
    // Test mode codes
    // ------------------------------------------------------------------
    localparam logic [3:0]  PMAAB_TM_NORMAL    = 4'h0;
    localparam logic [3:0]  PMAAB_TM_ONE       = 4'h2;
    localparam logic [3:0]  PMAAB_TM_TWO       = 4'h4;
    localparam logic [3:0]  PMAAB_TM_FOUR      = 4'h8;
    localparam logic [3:0]  PMAAB_TM_FIVE      = 4'hA;

endpackage : pmaab_pkg

// ==== hw/pmaab_sync.sv ====
// Two flip-flop synchroniser for a strap level
`timescale 1ns/1ps
module pmaab_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    // First stage is read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule : pmaab_sync

// ==== hw/pmaab_regs.sv ====
// Ability, role and test control registers behind a classic Wishbone slave
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module pmaab_regs (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [13:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Straps, from pins
    input  wire logic        strap_role_i,
    input  wire logic [3:0]  strap_test_i,
    // Control to the transceiver
    output logic             role_master_o,
    output logic [3:0]       test_mode_o,
    output logic             test_mode_valid_o
);
    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    logic [4:0] strap_sync;
    logic       strap_load_ff;

    pmaab_sync #(.WIDTH(5)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({strap_role_i, strap_test_i}),
        .q_o   (strap_sync)
    );

    // Straps load after sync settles; waits three edges past release
    logic [1:0] settle_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_ff     <= 2'h0;
            strap_load_ff <= 1'b1;
        end else if (settle_ff != 2'h2) begin
            settle_ff     <= settle_ff + 2'h1;
        end else begin
            strap_load_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        req;
    logic [11:0] idx;
    logic [3:0]  space;
    logic        hit_role;
    logic        hit_test;
    logic        wr_ok;

    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx      = wb_adr_i[11:0];
    assign space    = {2'h0, wb_adr_i[13:12]};
    // Upper address bits carry the device space selector; see R05
    assign hit_role = (space == pmaab_pkg::PMAAB_SPACE_PMA)
                      && (idx == pmaab_pkg::PMAAB_IDX_ROLE);
    assign hit_test = (space == pmaab_pkg::PMAAB_SPACE_PMA)
                      && (idx == pmaab_pkg::PMAAB_IDX_TEST);
    // Writable bits all live in the upper byte lane of the low half
    assign wr_ok    = req && wb_we_i && wb_sel_i[1];

    // ------------------------------------------------------------------
    // Writable state
    // ------------------------------------------------------------------
    logic       role_ff;
    logic [3:0] test_ff;

    // Role bit, strap default then software; see R03
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            role_ff <= 1'b0;
        end else if (strap_load_ff) begin
            role_ff <= strap_sync[4];
        end else if (wr_ok && hit_role) begin
            role_ff <= wb_dat_i[pmaab_pkg::PMAAB_ROLE_BIT];
        end
    end

    // Test field, strap default then software; see R04
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_ff <= pmaab_pkg::PMAAB_TM_NORMAL;
        end else if (strap_load_ff) begin
            test_ff <= strap_sync[3:0];
        end else if (wr_ok && hit_test) begin
            test_ff <= wb_dat_i[pmaab_pkg::PMAAB_TEST_LSB +: 4];
        end
    end

    // ------------------------------------------------------------------
    // Read mux; fixed bits ignore writes; see R06
    // ------------------------------------------------------------------
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (space == pmaab_pkg::PMAAB_SPACE_PMA) begin
            case (idx)
                pmaab_pkg::PMAAB_IDX_EXT_ONE:
                    rd_val = pmaab_pkg::PMAAB_EXT_ONE_VAL; // see R01
                pmaab_pkg::PMAAB_IDX_EXT_TWO:
                    rd_val = pmaab_pkg::PMAAB_EXT_TWO_VAL; // see R02
                pmaab_pkg::PMAAB_IDX_ROLE: begin
                    rd_val = pmaab_pkg::PMAAB_ROLE_FIXED;
                    rd_val[pmaab_pkg::PMAAB_ROLE_BIT] = role_ff; // see R03
                end
                pmaab_pkg::PMAAB_IDX_TEST: begin
                    rd_val = pmaab_pkg::PMAAB_TEST_FIXED;
                    rd_val[pmaab_pkg::PMAAB_TEST_LSB +: 4] = test_ff;
                end
                default: rd_val = 16'h0000; // Unmapped reads zero
            endcase
        end
    end

    // Ack one cycle after request; every address answers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {16'h0000, rd_val} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    logic tm_known;
    always_comb begin
        case (test_ff)
            pmaab_pkg::PMAAB_TM_NORMAL,
            pmaab_pkg::PMAAB_TM_ONE,
            pmaab_pkg::PMAAB_TM_TWO,
            pmaab_pkg::PMAAB_TM_FOUR,
            pmaab_pkg::PMAAB_TM_FIVE: tm_known = 1'b1; // see R04
            default:                  tm_known = 1'b0;
        endcase
    end

    // Registered copies so outputs come straight from flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            role_master_o     <= 1'b0;
            test_mode_o       <= pmaab_pkg::PMAAB_TM_NORMAL;
            test_mode_valid_o <= 1'b0;
        end else begin
            role_master_o     <= role_ff;
            test_mode_o       <= test_ff;
            test_mode_valid_o <= tm_known;
        end
    end
endmodule : pmaab_regs

// ==== tb/pmaab_monitor.sv ====
// Checker: bus timing and fixed read values of the ability bank
`timescale 1ns/1ps
module pmaab_monitor (
    // Watched ports
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [13:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [3:0]  test_mode_o,
    input  wire logic        test_mode_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A request being taken, and a read of one word
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_s(logic [13:0] a);
        take_s ##0 !wb_we_i && wb_adr_i == a;
    endsequence
    ack_time_a: assert property (take_s |=> wb_ack_o)
        else $error("ack late");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data while idle");
    ext_one_a: assert property (rd_s(14'h100B) |=> wb_dat_o == 32'h0800)
        else $error("ext one value");
    ext_two_a: assert property (rd_s(14'h1012) |=> wb_dat_o == 32'h0001)
        else $error("ext two value");
    role_fixed_a: assert property (rd_s(14'h1834) |=>
        (wb_dat_o & 32'hFFFFBFFF) == 32'h8000) else $error("role fixed bits");
    test_fixed_a: assert property (rd_s(14'h1836) |=>
        (wb_dat_o & 32'hFFFF0FFF) == 32'h0001) else $error("test fixed bits");
    space_zero_a: assert property (take_s ##0 wb_adr_i[13:12] != 2'h1
        |=> wb_dat_o == 32'h0) else $error("other space not zero");
    code_flag_a: assert property ($stable(test_mode_o) [*3] |->
        test_mode_valid_o == (test_mode_o inside {4'h0, 4'h2, 4'h4, 4'h8, 4'hA}))
        else $error("test code flag");
endmodule : pmaab_monitor

// ==== tb/pmaab_host.sv ====
// Management host model issuing classic Wishbone cycles
`timescale 1ns/1ps
module pmaab_host (
    // Clock and bus
    input  wire logic        clk_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [13:0]      adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    // Count of cycles that never saw ack; the bench folds it into its verdict
    int tmo = 0;
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // One cycle; data line inverted once released so stale values never match
    task acc(input logic w, input logic [1:0] sp, input logic [11:0] i,
             input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, sel_o, dat_o} <= {2'b11, w, s, d};
        adr_o <= {sp, i};
        do @(posedge clk_i); while (ack_i !== 1'b1 && n++ < 64);
        if (ack_i !== 1'b1) begin
            tmo++;
        end
        q = dat_i;
        {cyc_o, stb_o, dat_o} <= {2'b00, ~d};
    endtask : acc
endmodule : pmaab_host

// ==== tb/tb.sv ====
// Self-checking bench of the ability bank
`timescale 1ns/1ps
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sr, cyc, stb, we, ack, rm, tv;
    logic [3:0]  st, sel, tm;
    logic [13:0] adr;
    logic [31:0] wd, rdt, q;
    int          err_total = 0;
    int          checks = 0;
    logic [3:0]  codes [6] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hA, 4'h3};
    always #12.5 clk_i = ~clk_i;
    pmaab_host u_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wd), .dat_i(rdt), .ack_i(ack));
    pmaab_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rdt), .wb_ack_o(ack), .strap_role_i(sr),
        .strap_test_i(st), .role_master_o(rm), .test_mode_o(tm),
        .test_mode_valid_o(tv));
    // Expected read word
    function logic [31:0] exp_rd(logic [11:0] i, logic r, logic [3:0] t);
        case (i)
            12'h00B: return 32'h0800;
            12'h012: return 32'h0001;
            12'h834: return {16'h0, 1'b1, r, 14'h0};
            12'h836: return {16'h0, t, 12'h001};
            default: return 32'h0;
        endcase
    endfunction : exp_rd
    task cmp(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task rd(logic [11:0] i, logic r, logic [3:0] t);
        u_host.acc(1'b0, 2'h1, i, $urandom, 4'hF, q);
        cmp("read", exp_rd(i, r, t), q);
    endtask : rd
    task close_out;
        err_total += u_host.tmo;
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // Main sequence: straps, fixed words, the five mode codes plus unknown code 3, role, other space
    initial begin
        logic        r;
        logic [3:0]  t;
        logic [31:0] d;
        void'($urandom(32'h9555));
        sr = $urandom;
        st = $urandom;
        r = sr;
        t = st;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        cmp("role out", {31'h0, r}, {31'h0, rm});
        cmp("test out", {28'h0, t}, {28'h0, tm});
        rd(12'h834, r, t);
        rd(12'h836, r, t);
        foreach (codes[k]) begin
            u_host.acc(1'b1, 2'h1, k < 2 ? 12'h00B : 12'h012, '1, 4'hF, q);
            rd(k < 2 ? 12'h00B : 12'h012, r, t);
            t = codes[k];
            d = $urandom;
            d[15:12] = t;
            u_host.acc(1'b1, 2'h1, 12'h836, d, 4'hF, q);
            rd(12'h836, r, t);
            repeat (2) @(posedge clk_i);
            cmp("mode", {28'h0, t}, {28'h0, tm});
            cmp("flag", {31'h0, k < 5}, {31'h0, tv});
        end
        for (int k = 0; k < 3; k++) begin
            d = $urandom;
            d[14] = (k != 0) ^ r;
            u_host.acc(1'b1, 2'h1, 12'h834, d, k < 2 ? 4'hF : 4'hD, q);
            r = k < 2 ? d[14] : r;
            rd(12'h834, r, t);
            repeat (2) @(posedge clk_i);
            cmp("role", {31'h0, r}, {31'h0, rm});
        end
        u_host.acc(1'b0, 2'h2, 12'h834, 32'h0, 4'hF, q);
        cmp("space", 32'h0, q);
        close_out();
    end
    // Watchdog, far beyond the expected run length
    initial begin
        repeat (4000) @(posedge clk_i);
        err_total++;
        close_out();
    end
endmodule : tb
bind pmaab_regs pmaab_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .test_mode_o(test_mode_o), .test_mode_valid_o(test_mode_valid_o));
